// [hdl/dispd_pkg.sv]
// package for the two-wire dac slave and its bus master
// assumes a 250 MHz system clock on both ends of the link
package dispd_pkg;
   // system clock and link timing
   localparam int CLK_PERIOD_NS = 4;
   localparam int SCL_MIN_PERIOD_NS = 2500;
   localparam int SCL_QTR_CYC_INT = (SCL_MIN_PERIOD_NS + 4 * CLK_PERIOD_NS - 1)
                                    / (4 * CLK_PERIOD_NS);
   localparam logic [7:0] SCL_QTR_CYC = 8'(SCL_QTR_CYC_INT);
   // frame layout
   localparam logic [3:0] BIT_LAST_DATA = 4'h7;
   localparam logic [3:0] BIT_ACK = 4'h8;
   localparam logic [1:0] BYTE_LAST = 2'h2;
   // slave address upper bits, default factory variant
   localparam logic [5:0] ADDR_UPPER_DEFAULT = 6'h08;
   // command nibbles
   localparam logic [3:0] CMD_LOAD_BOTH = 4'hC;
   localparam logic [3:0] CMD_LOAD_INPUT = 4'hD;
   localparam logic [3:0] CMD_INPUT_SWAP = 4'hE;
   localparam logic [3:0] CMD_UPDATE_DAC = 4'hF;
   localparam logic [1:0] CMD_TOP_PWRDN = 2'h1;
   // power-down selection codes
   localparam logic [1:0] PD_AWAKE = 2'h0;
   localparam logic [1:0] PD_FLOAT = 2'h1;
   localparam logic [1:0] PD_PULL_1K = 2'h2;
   localparam logic [1:0] PD_PULL_100K = 2'h3;
   // reset values
   localparam logic [9:0] CODE_RESET = 10'h000;
   localparam logic [1:0] PD_RESET = PD_PULL_100K;
   // read-back padding
   localparam logic [3:0] RD_PAD_HI = 4'h0;
   localparam logic [1:0] RD_PAD_LO = 2'h0;
   // slave states
   typedef enum logic [1:0] {
      DS_OFF = 2'b00,
      DS_ADDR = 2'b01,
      DS_WRITE = 2'b11,
      DS_READ = 2'b10
   } dispd_dev_st_type;
   // master states
   typedef enum logic [1:0] {
      HS_IDLE = 2'b00,
      HS_START = 2'b01,
      HS_BIT = 2'b11,
      HS_STOP = 2'b10
   } dispd_host_st_type;
endpackage : dispd_pkg

// [hdl/dispd_link_if.sv]
// two-wire link between the dac slave and its bus master
// assumes open-drain pins with pull-ups; enables are active low
`timescale 1ns/1ns
`default_nettype none
interface dispd_link_if;
   logic scl_host_o;
   logic scl_host_oe_n;
   logic sda_host_o;
   logic sda_host_oe_n;
   logic sda_dev_o;
   logic sda_dev_oe_n;
   logic scl_line;
   logic sda_line;
   // wired-and of the open-drain drivers with pull-ups
   assign scl_line = scl_host_oe_n | scl_host_o;
   assign sda_line = (sda_host_oe_n | sda_host_o) & (sda_dev_oe_n | sda_dev_o);
   modport dev (input scl_line, input sda_line, output sda_dev_o, output sda_dev_oe_n);
   modport host (input scl_line, input sda_line, output scl_host_o, output scl_host_oe_n,
      output sda_host_o, output sda_host_oe_n);
endinterface : dispd_link_if
`default_nettype wire

// [hdl/dispd_dev.sv]
// two-wire slave interface and power-down control of a 10-bit dac
// assumes the link signals and the address-select pin are asynchronous
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
// Contract
// - reset clears codes, selects 100k power-down
// - master sends wake-up before expecting output
// - two-bit selection picks awake or termination
// - codes survive power-down, output restored after
// - slave only, master clocks at 400kHz
// - eight bits plus one acknowledge clock
// - data stable while clock high
// - start and stop detected with clock high
// - master ends with nack then stop
// - after stop or mismatch, wait for start
// - stop accepted except in start's high pulse
// - writes chain freely, reads need repeated start
// - slave pulls ninth bit low on receive
// - slave releases ninth bit when sending
// - master retries after a missing acknowledge (dispd_host sends stop and reports rsp_nack instead)
// - address compared bit by bit, early drop
// - eighth bit gives direction, one reads
// - six fixed bits, lowest from select pin
// - power-down command writes the selection bits
// - registers update at acknowledge falling edge
// - read returns dac register as two bytes
module dispd_dev #(
   parameter logic [5:0] ADDR_UPPER = dispd_pkg::ADDR_UPPER_DEFAULT
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   dispd_link_if.dev link,
   input wire logic addr_sel_i,
   output logic [9:0] dac_code_o,
   output logic [9:0] input_code_o,
   output logic [1:0] pwrdn_sel_o,
   output logic buffer_en_o,
   output logic term_1k_o,
   output logic term_100k_o,
   output logic engaged_o
);
   typedef struct packed {
      logic scl_m;
      logic scl_s;
      logic scl_d;
      logic sda_m;
      logic sda_s;
      logic sda_d;
      logic add_m;
      logic add_s;
      dispd_pkg::dispd_dev_st_type st;
      logic [3:0] bitcnt;
      logic [7:0] rxsh;
      logic [7:0] txsh;
      logic [7:0] hold;
      logic byte_idx;
      logic rw;
      logic mnack;
      logic sta_hi;
      logic sda_oe_n;
      logic [9:0] in_reg;
      logic [9:0] dac_reg;
      logic [1:0] pd;
   } dispd_dev_state_type;

   dispd_dev_state_type s_ff;
   dispd_dev_state_type nxt_s;

   logic rise;
   logic fall;
   logic start;
   logic stop;
   logic [6:0] addr7;
   logic [6:0] addr_shift;
   logic [7:0] rd_byte0;
   logic [7:0] rd_byte1;
   logic [9:0] new_code;

   // edge and condition detection on the synchronised lines
   assign rise = s_ff.scl_s & ~s_ff.scl_d;
   assign fall = ~s_ff.scl_s & s_ff.scl_d;
   assign start = s_ff.scl_s & s_ff.scl_d & s_ff.sda_d & ~s_ff.sda_s;
   assign stop = s_ff.scl_s & s_ff.scl_d & ~s_ff.sda_d & s_ff.sda_s;
   assign addr7 = {ADDR_UPPER, s_ff.add_s};
   assign addr_shift = addr7 << s_ff.bitcnt;
   assign rd_byte0 = {dispd_pkg::RD_PAD_HI, s_ff.dac_reg[9:6]};
   assign rd_byte1 = {s_ff.dac_reg[5:0], dispd_pkg::RD_PAD_LO};
   assign new_code = {s_ff.hold[3:0], s_ff.rxsh[7:2]};

   // next-state logic of the whole slave
   always_comb
   begin
      nxt_s = s_ff;
      nxt_s.scl_m = link.scl_line;
      nxt_s.scl_s = s_ff.scl_m;
      nxt_s.scl_d = s_ff.scl_s;
      nxt_s.sda_m = link.sda_line;
      nxt_s.sda_s = s_ff.sda_m;
      nxt_s.sda_d = s_ff.sda_s;
      nxt_s.add_m = addr_sel_i;
      nxt_s.add_s = s_ff.add_m;
      if (fall)
      begin
         nxt_s.sta_hi = 1'b0;
      end
      if (start)
      begin
         nxt_s.st = dispd_pkg::DS_ADDR;
         nxt_s.bitcnt = 4'h0;
         nxt_s.byte_idx = 1'b0;
         nxt_s.mnack = 1'b0;
         nxt_s.sda_oe_n = 1'b1;
         nxt_s.sta_hi = 1'b1;
      end
      // stop in the start's high pulse ignored
      else if (stop && !s_ff.sta_hi && s_ff.st != dispd_pkg::DS_OFF)
      begin
         nxt_s.st = dispd_pkg::DS_OFF;
         nxt_s.sda_oe_n = 1'b1;
      end
      else if (s_ff.st != dispd_pkg::DS_OFF)
      begin
         // data sampled on the rising clock
         if (rise)
         begin
            if (s_ff.bitcnt < dispd_pkg::BIT_ACK)
            begin
               nxt_s.rxsh = {s_ff.rxsh[6:0], s_ff.sda_s};
               if (s_ff.st == dispd_pkg::DS_ADDR && s_ff.bitcnt < dispd_pkg::BIT_LAST_DATA
                   && s_ff.sda_s != addr_shift[6])
               begin
                  nxt_s.st = dispd_pkg::DS_OFF;
                  nxt_s.sda_oe_n = 1'b1;
               end
               if (s_ff.st == dispd_pkg::DS_ADDR && s_ff.bitcnt == dispd_pkg::BIT_LAST_DATA)
               begin
                  nxt_s.rw = s_ff.sda_s;
               end
            end
            else if (s_ff.st == dispd_pkg::DS_READ)
            begin
               nxt_s.mnack = s_ff.sda_s;
            end
         end
         // eight bits then acknowledge slot; the start's own fall is no bit
         if (fall && !s_ff.sta_hi)
         begin
            if (s_ff.bitcnt < dispd_pkg::BIT_LAST_DATA)
            begin
               nxt_s.bitcnt = s_ff.bitcnt + 4'h1;
               if (s_ff.st == dispd_pkg::DS_READ)
               begin
                  nxt_s.txsh = {s_ff.txsh[6:0], 1'b0};
                  nxt_s.sda_oe_n = s_ff.txsh[6];
               end
            end
            else if (s_ff.bitcnt == dispd_pkg::BIT_LAST_DATA)
            begin
               nxt_s.bitcnt = dispd_pkg::BIT_ACK;
               nxt_s.sda_oe_n = (s_ff.st == dispd_pkg::DS_READ);
            end
            else
            begin
               nxt_s.bitcnt = 4'h0;
               nxt_s.sda_oe_n = 1'b1;
               case (s_ff.st)
                  dispd_pkg::DS_ADDR:
                  begin
                     nxt_s.byte_idx = 1'b0;
                     // slave sends only on master's clock
                     if (s_ff.rw)
                     begin
                        nxt_s.st = dispd_pkg::DS_READ;
                        nxt_s.txsh = rd_byte0;
                        nxt_s.sda_oe_n = rd_byte0[7];
                     end
                     else
                     begin
                        nxt_s.st = dispd_pkg::DS_WRITE;
                     end
                  end
                  dispd_pkg::DS_WRITE:
                  begin
                     nxt_s.byte_idx = ~s_ff.byte_idx;
                     if (!s_ff.byte_idx)
                     begin
                        nxt_s.hold = s_ff.rxsh;
                     end
                     else
                     begin
                        case (s_ff.hold[7:4])
                           dispd_pkg::CMD_LOAD_BOTH:
                           begin
                              nxt_s.in_reg = new_code;
                              nxt_s.dac_reg = new_code;
                           end
                           dispd_pkg::CMD_LOAD_INPUT:
                           begin
                              nxt_s.in_reg = new_code;
                           end
                           dispd_pkg::CMD_INPUT_SWAP:
                           begin
                              nxt_s.in_reg = new_code;
                              nxt_s.dac_reg = s_ff.in_reg;
                           end
                           dispd_pkg::CMD_UPDATE_DAC:
                           begin
                              nxt_s.dac_reg = s_ff.in_reg;
                           end
                           default:
                           begin
                              if (s_ff.hold[7:6] == dispd_pkg::CMD_TOP_PWRDN)
                              begin
                                 nxt_s.pd = s_ff.hold[3:2];
                              end
                           end
                        endcase
                     end
                  end
                  dispd_pkg::DS_READ:
                  begin
                     if (s_ff.mnack)
                     begin
                        nxt_s.st = dispd_pkg::DS_OFF;
                     end
                     else
                     begin
                        nxt_s.byte_idx = ~s_ff.byte_idx;
                        nxt_s.txsh = s_ff.byte_idx ? rd_byte0 : rd_byte1;
                        nxt_s.sda_oe_n = s_ff.byte_idx ? rd_byte0[7] : rd_byte1[7];
                     end
                  end
                  default:
                  begin
                     nxt_s.st = dispd_pkg::DS_OFF;
                  end
               endcase
            end
         end
      end
   end

   // state register; zero codes, 100k power-down
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         s_ff <= '{scl_m: 1'b1, scl_s: 1'b1, scl_d: 1'b1, sda_m: 1'b1, sda_s: 1'b1,
                   sda_d: 1'b1, add_m: 1'b0, add_s: 1'b0, st: dispd_pkg::DS_OFF,
                   bitcnt: 4'h0, rxsh: 8'h00, txsh: 8'h00, hold: 8'h00, byte_idx: 1'b0,
                   rw: 1'b0, mnack: 1'b0, sta_hi: 1'b0, sda_oe_n: 1'b1,
                   in_reg: dispd_pkg::CODE_RESET, dac_reg: dispd_pkg::CODE_RESET,
                   pd: dispd_pkg::PD_RESET};
      end
      else
      begin
         s_ff <= nxt_s;
      end
   end

   // outputs; selection decode, codes kept
   assign link.sda_dev_o = 1'b0;
   assign link.sda_dev_oe_n = s_ff.sda_oe_n;
   assign dac_code_o = s_ff.dac_reg;
   assign input_code_o = s_ff.in_reg;
   assign pwrdn_sel_o = s_ff.pd;
   assign buffer_en_o = (s_ff.pd == dispd_pkg::PD_AWAKE);
   assign term_1k_o = (s_ff.pd == dispd_pkg::PD_PULL_1K);
   assign term_100k_o = (s_ff.pd == dispd_pkg::PD_PULL_100K);
   assign engaged_o = (s_ff.st != dispd_pkg::DS_OFF);
endmodule : dispd_dev
`default_nettype wire

// [hdl/dispd_host.sv]
// two-wire bus master that drives the dac slave
// assumes a user that issues one command at a time on the command port
`timescale 1ns/1ns
`default_nettype none
module dispd_host (
   input wire logic clk_i,
   input wire logic reset_n_i,
   dispd_link_if.host link,
   input wire logic cmd_valid_i,
   output logic cmd_ready_o,
   input wire logic cmd_read_i,
   input wire logic [6:0] cmd_addr_i,
   input wire logic [15:0] cmd_word_i,
   output logic rsp_valid_o,
   output logic rsp_nack_o,
   output logic [15:0] rsp_data_o
);
   typedef struct packed {
      logic sda_m;
      logic sda_s;
      dispd_pkg::dispd_host_st_type st;
      logic [7:0] qcnt;
      logic [1:0] ph;
      logic [3:0] bitcnt;
      logic [1:0] bytecnt;
      logic rd;
      logic nack;
      logic [23:0] tx;
      logic [15:0] rx;
      logic scl_oe_n;
      logic sda_oe_n;
      logic rsp_valid;
      logic rsp_nack;
      logic [15:0] rsp_data;
   } dispd_host_state_type;

   dispd_host_state_type s_ff;
   dispd_host_state_type nxt_s;

   logic tick;
   logic mtx;
   logic drv_low;

   // quarter-period tick and who owns the data line this byte
   assign tick = (s_ff.qcnt == dispd_pkg::SCL_QTR_CYC - 8'h01);
   assign mtx = (s_ff.bytecnt == 2'h0) | ~s_ff.rd;
   // receiver acks; nack on last byte
   assign drv_low = (s_ff.bitcnt < dispd_pkg::BIT_ACK) ? (mtx & ~s_ff.tx[23])
                    : (~mtx & (s_ff.bytecnt != dispd_pkg::BYTE_LAST));

   // next-state logic of the master
   always_comb
   begin
      nxt_s = s_ff;
      nxt_s.sda_m = link.sda_line;
      nxt_s.sda_s = s_ff.sda_m;
      nxt_s.rsp_valid = 1'b0;
      if (s_ff.st == dispd_pkg::HS_IDLE)
      begin
         nxt_s.qcnt = 8'h00;
         nxt_s.ph = 2'h0;
         // wake-up is an ordinary user command
         if (cmd_valid_i)
         begin
            nxt_s.st = dispd_pkg::HS_START;
            nxt_s.rd = cmd_read_i;
            nxt_s.tx = {cmd_addr_i, cmd_read_i, cmd_word_i};
            nxt_s.bitcnt = 4'h0;
            nxt_s.bytecnt = 2'h0;
            nxt_s.nack = 1'b0;
         end
      end
      else
      begin
         // quarter periods keep the clock under 400kHz
         nxt_s.qcnt = tick ? 8'h00 : s_ff.qcnt + 8'h01;
         if (tick)
         begin
            nxt_s.ph = s_ff.ph + 2'h1;
            case (s_ff.st)
               dispd_pkg::HS_START:
               begin
                  if (s_ff.ph == 2'h0)
                  begin
                     nxt_s.sda_oe_n = 1'b0;
                  end
                  else
                  begin
                     nxt_s.scl_oe_n = 1'b0;
                     nxt_s.st = dispd_pkg::HS_BIT;
                     nxt_s.ph = 2'h0;
                  end
               end
               dispd_pkg::HS_BIT:
               begin
                  case (s_ff.ph)
                     // data changes only with clock low
                     2'h0: nxt_s.sda_oe_n = ~drv_low;
                     2'h1: nxt_s.scl_oe_n = 1'b1;
                     2'h3:
                     begin
                        nxt_s.scl_oe_n = 1'b0;
                        if (s_ff.bitcnt < dispd_pkg::BIT_ACK)
                        begin
                           nxt_s.bitcnt = s_ff.bitcnt + 4'h1;
                           if (mtx)
                           begin
                              nxt_s.tx = {s_ff.tx[22:0], 1'b0};
                           end
                           else
                           begin
                              nxt_s.rx = {s_ff.rx[14:0], s_ff.sda_s};
                           end
                        end
                        else
                        begin
                           nxt_s.bitcnt = 4'h0;
                           if (mtx && s_ff.sda_s)
                           begin
                              nxt_s.nack = 1'b1;
                              nxt_s.st = dispd_pkg::HS_STOP;
                           end
                           else if (s_ff.bytecnt == dispd_pkg::BYTE_LAST)
                           begin
                              nxt_s.st = dispd_pkg::HS_STOP;
                           end
                           else
                           begin
                              nxt_s.bytecnt = s_ff.bytecnt + 2'h1;
                           end
                        end
                     end
                     default:
                     begin
                        nxt_s.ph = s_ff.ph + 2'h1;
                     end
                  endcase
               end
               dispd_pkg::HS_STOP:
               begin
                  // stop after last ack; clocks precede it
                  // each transfer framed by its own start
                  case (s_ff.ph)
                     2'h0: nxt_s.sda_oe_n = 1'b0;
                     2'h1: nxt_s.scl_oe_n = 1'b1;
                     2'h2: nxt_s.sda_oe_n = 1'b1;
                     default:
                     begin
                        nxt_s.st = dispd_pkg::HS_IDLE;
                        nxt_s.rsp_valid = 1'b1;
                        nxt_s.rsp_nack = s_ff.nack;
                        nxt_s.rsp_data = s_ff.rx;
                     end
                  endcase
               end
               default:
               begin
                  nxt_s.st = dispd_pkg::HS_IDLE;
               end
            endcase
         end
      end
   end

   // state register
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         s_ff <= '{sda_m: 1'b1, sda_s: 1'b1, st: dispd_pkg::HS_IDLE, qcnt: 8'h00,
                   ph: 2'h0, bitcnt: 4'h0, bytecnt: 2'h0, rd: 1'b0, nack: 1'b0,
                   tx: 24'h000000, rx: 16'h0000, scl_oe_n: 1'b1, sda_oe_n: 1'b1,
                   rsp_valid: 1'b0, rsp_nack: 1'b0, rsp_data: 16'h0000};
      end
      else
      begin
         s_ff <= nxt_s;
      end
   end

   // outputs
   assign link.scl_host_o = 1'b0;
   assign link.scl_host_oe_n = s_ff.scl_oe_n;
   assign link.sda_host_o = 1'b0;
   assign link.sda_host_oe_n = s_ff.sda_oe_n;
   assign cmd_ready_o = (s_ff.st == dispd_pkg::HS_IDLE);
   assign rsp_valid_o = s_ff.rsp_valid;
   assign rsp_nack_o = s_ff.rsp_nack;
   assign rsp_data_o = s_ff.rsp_data;
endmodule : dispd_host
`default_nettype wire

// [testbench/dispd_link_assertions.sv]
// checker on the two-wire link between the dac slave and its master
// assumes plain copies of the shared link signals and one clock domain
`timescale 1ns/1ns
`default_nettype none
module dispd_link_assertions (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic scl_line,
   input wire logic sda_line,
   input wire logic sda_dev_oe_n
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   logic scl_q_ff, sda_q_ff, busy_ff, rd_ff;
   logic [5:0] fall_cnt_ff;
   logic [9:0] rise_age_ff, fall_age_ff;
   logic rise, fall, start, stop;
   // line edges and bus conditions
   assign rise = scl_line & ~scl_q_ff;
   assign fall = ~scl_line & scl_q_ff;
   assign start = scl_line & scl_q_ff & sda_q_ff & ~sda_line;
   assign stop = scl_line & scl_q_ff & ~sda_q_ff & sda_line;
   // frame tracking: clock falls since start, direction, edge ages
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         {scl_q_ff, sda_q_ff, busy_ff, rd_ff} <= 4'hC;
         fall_cnt_ff <= 6'h00;
         rise_age_ff <= 10'h3FF;
         fall_age_ff <= 10'h3FF;
      end
      else
      begin
         scl_q_ff <= scl_line;
         sda_q_ff <= sda_line;
         busy_ff <= start | (busy_ff & ~stop);
         rd_ff <= start ? 1'b0 : ((rise && fall_cnt_ff == 6'h08) ? sda_line : rd_ff);
         fall_cnt_ff <= start ? 6'h00 : fall_cnt_ff + 6'(fall);
         rise_age_ff <= rise ? 10'h000 : rise_age_ff + 10'(rise_age_ff != 10'h3FF);
         fall_age_ff <= fall ? 10'h000 : fall_age_ff + 10'(fall_age_ff != 10'h3FF);
      end
   end
   scl_rate_a: assert property (rise |-> rise_age_ff >= 10'd624)
      else $error("clock period below limit");
   byte_frame_a: assert property (stop && busy_ff |-> (fall_cnt_ff % 6'd9) == 6'd1)
      else $error("frame not whole bytes");
   start_clock_a: assert property (start |-> ##[1:300] !scl_line)
      else $error("no clock pulse after start");
   ack_slot_a: assert property (scl_line && !sda_dev_oe_n && !rd_ff |-> (fall_cnt_ff % 6'd9) == 6'd0)
      else $error("slave pulls data outside ack slot");
   read_release_a: assert property (rd_ff && scl_line && fall_cnt_ff > 6'd9
      && (fall_cnt_ff % 6'd9) == 6'd0 |-> sda_dev_oe_n)
      else $error("slave holds data in master ack");
   idle_release_a: assert property (!busy_ff |-> sda_dev_oe_n)
      else $error("slave drives data while idle");
   dev_hold_a: assert property (scl_line && scl_q_ff |-> $stable(sda_dev_oe_n))
      else $error("slave data moved with clock high");
   dev_turn_a: assert property ($changed(sda_dev_oe_n) |-> fall_age_ff inside {[1:6]})
      else $error("slave data change not after clock fall");
   // main scenarios seen on the link
   start_c: cover property (start);
   stop_c: cover property (stop && busy_ff);
   read_c: cover property (stop && rd_ff);
   ack_c: cover property (scl_line && !sda_dev_oe_n);
endmodule : dispd_link_assertions
`default_nettype wire

// [testbench/dispd_test.sv]
// self-checking bench: master and slave joined, user side driven here
// assumes a 250 MHz clock; the address-select pin starts high and is pulled low mid-run
`timescale 1ns/1ns
`default_nettype none
module dispd_test;
   localparam logic [6:0] DEV_ADDR = {dispd_pkg::ADDR_UPPER_DEFAULT, 1'b1};
   localparam logic [6:0] DEV_ADDR_LO = {dispd_pkg::ADDR_UPPER_DEFAULT, 1'b0};
   localparam logic [9:0] CODE = 10'h2A5;
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic cmd_valid_i = 1'b0;
   logic addr_sel_i = 1'b1;
   logic cmd_read_i = 1'b0;
   logic [6:0] cmd_addr_i = 7'h00;
   logic [15:0] cmd_word_i = 16'h0000;
   logic cmd_ready_o, rsp_valid_o, rsp_nack_o, buffer_en_o, term_1k_o, term_100k_o, engaged_o;
   logic [15:0] rsp_data_o, outs;
   logic [9:0] dac_code_o, input_code_o;
   logic [1:0] pwrdn_sel_o;
   int n_fail = 0;
   int num_checks = 0;
   int cycles = 0;
   // slave outputs packed for one-shot compares
   assign outs = {dac_code_o, pwrdn_sel_o, buffer_en_o, term_1k_o, term_100k_o, engaged_o};
   always #2 clk_i = ~clk_i;
   dispd_link_if dispd_link_if_inst ();
   dispd_dev dispd_dev_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .link(dispd_link_if_inst),
      .addr_sel_i(addr_sel_i), .dac_code_o(dac_code_o), .input_code_o(input_code_o),
      .pwrdn_sel_o(pwrdn_sel_o), .buffer_en_o(buffer_en_o), .term_1k_o(term_1k_o),
      .term_100k_o(term_100k_o), .engaged_o(engaged_o));
   dispd_host dispd_host_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .link(dispd_link_if_inst),
      .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .cmd_read_i(cmd_read_i),
      .cmd_addr_i(cmd_addr_i), .cmd_word_i(cmd_word_i), .rsp_valid_o(rsp_valid_o),
      .rsp_nack_o(rsp_nack_o), .rsp_data_o(rsp_data_o));
   dispd_link_assertions dispd_link_assertions_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .scl_line(dispd_link_if_inst.scl_line), .sda_line(dispd_link_if_inst.sda_line),
      .sda_dev_oe_n(dispd_link_if_inst.sda_dev_oe_n));
   // verdict and end of run
   task automatic complete_run();
      if (n_fail == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : complete_run
   // compare one value and count it
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
         n_fail++;
      end
   endtask : chk
   // one command frame, waits for its end and checks the ack outcome
   task automatic frame(input logic rd, input logic [6:0] addr, input logic [15:0] word,
      input logic nack);
      @(posedge clk_i);
      cmd_valid_i <= 1'b1;
      cmd_read_i <= rd;
      cmd_addr_i <= addr;
      cmd_word_i <= word;
      @(posedge clk_i);
      cmd_valid_i <= 1'b0;
      @(negedge clk_i);
      chk(16'(cmd_ready_o), 16'h0000);
      do @(negedge clk_i); while (rsp_valid_o !== 1'b1);
      chk(16'(cmd_ready_o), 16'h0001);
      chk(16'(rsp_nack_o), 16'(nack));
   endtask : frame
   // reset state: zero codes, 100k termination, interface off
   task automatic t_reset();
      chk(outs, {10'h000, dispd_pkg::PD_PULL_100K, 4'b0010});
      chk(16'(input_code_o), 16'h0000);
   endtask : t_reset
   // wake-up command powers the output stage up
   task automatic t_wake();
      frame(1'b0, DEV_ADDR, 16'h4000, 1'b0);
      chk(outs, {10'h000, dispd_pkg::PD_AWAKE, 4'b1000});
   endtask : t_wake
   // load both registers at once
   task automatic t_load();
      frame(1'b0, DEV_ADDR, {dispd_pkg::CMD_LOAD_BOTH, CODE, 2'b00}, 1'b0);
      chk(outs, {CODE, dispd_pkg::PD_AWAKE, 4'b1000});
      chk(16'(input_code_o), 16'(CODE));
   endtask : t_load
   // pin pulled low, then floating power-down at the new address keeps the codes
   task automatic t_float();
      @(posedge clk_i);
      addr_sel_i <= 1'b0;
      frame(1'b0, DEV_ADDR_LO, 16'h4400, 1'b0);
      chk(outs, {CODE, dispd_pkg::PD_FLOAT, 4'b0000});
   endtask : t_float
   // 1k power-down, output stage off, codes kept
   task automatic t_pull_1k();
      frame(1'b0, DEV_ADDR_LO, 16'h4800, 1'b0);
      chk(outs, {CODE, dispd_pkg::PD_PULL_1K, 4'b0100});
   endtask : t_pull_1k
   // read-back of the dac register in two bytes
   task automatic t_read();
      frame(1'b1, DEV_ADDR_LO, 16'h0000, 1'b0);
      chk(rsp_data_o, {dispd_pkg::RD_PAD_HI, CODE, dispd_pkg::RD_PAD_LO});
   endtask : t_read
   // address off in the pin bit only: refused, state untouched
   task automatic t_wrong();
      frame(1'b0, DEV_ADDR, 16'h4C00, 1'b1);
      chk(outs, {CODE, dispd_pkg::PD_PULL_1K, 4'b0100});
   endtask : t_wrong
   // hang guard
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 99000)
      begin
         n_fail++;
         complete_run();
      end
   end
   // main sequence
   initial
   begin
      repeat (4) @(posedge clk_i);
      reset_n_i <= 1'b1;
      @(negedge clk_i);
      t_reset();
      t_wake();
      t_load();
      t_float();
      t_pull_1k();
      t_read();
      t_wrong();
      complete_run();
   end
endmodule : dispd_test
`default_nettype wire
